/* pkg/acc_consts.svh */
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_PWR 8'h08
`define ACC_IDX_DCS 8'h09
`define ACC_IDX_DIV 8'h0b
`define ACC_IDX_OUT 8'h14
`define ACC_IDX_SYNC 8'h3a
`define ACC_IDX_PATH 8'h40
`define ACC_IDX_STAT 8'h7f

// Field positions
`define ACC_PWR_PD_BIT 0
`define ACC_PWR_SB_BIT 1
`define ACC_DCS_EN_BIT 0
`define ACC_SYNC_EN_BIT 1
`define ACC_SYNC_ONCE_BIT 2
`define ACC_OUT_FMT_LSB 0
`define ACC_OUT_DIS_A_BIT 4
`define ACC_OUT_DIS_B_BIT 5
`define ACC_PATH_LONG_BIT 0
`define ACC_STAT_LOCK_BIT 0
`define ACC_STAT_PD_BIT 1
`define ACC_STAT_SB_BIT 2
`define ACC_STAT_ARM_BIT 3
`define ACC_STAT_WAKE_BIT 4

// Reset values
`define ACC_DCS_EN_RST 1'b1
`define ACC_DIV_RST 3'h0
`define ACC_FMT_RST 2'h0

// Output formats
`define ACC_FMT_TWOS 2'h0
`define ACC_FMT_OFFS 2'h1
`define ACC_FMT_GRAY 2'h2

// Converter limits
`define ACC_FS_POS 16'sh1fff
`define ACC_FS_NEG 16'she000
`define ACC_CODE_POS 14'h1fff
`define ACC_CODE_NEG 14'h2000

// Latencies in internal sample clocks
`define ACC_LAT_SHORT 23
`define ACC_LAT_LONG 43
`define ACC_OR_LAT 10

// Timing
`define ACC_CLK_MHZ 200
`define ACC_DCS_MIN_MHZ 40
`define ACC_DCS_RELOCK_NS 1500
`define ACC_DCS_RELOCK_CYC ((`ACC_DCS_RELOCK_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_WAKE_PD_NS 1000
`define ACC_WAKE_PD_CYC ((`ACC_WAKE_PD_NS * `ACC_CLK_MHZ + 999) / 1000)
`define ACC_WAKE_SB_NS 100
`define ACC_WAKE_SB_CYC ((`ACC_WAKE_SB_NS * `ACC_CLK_MHZ + 999) / 1000)

`endif

/* pkg/acc_pkg.sv */
package acc_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [9:0] paddr;
        logic [31:0] pwdata;
    } acc_apb_req_t;

    typedef struct packed {
        logic [15:0] chanA;
        logic [15:0] chanB;
    } acc_samples_t;

    typedef struct packed {
        logic [13:0] data;
        logic overRange;
        logic dataClk;
        logic dataOeB;
        logic clkOeB;
        logic orOeB;
    } acc_out_t;

    typedef struct packed {
        logic [2:0] pin1;
        logic [2:0] pin2;
        logic syncPrev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pdBit;
        logic sbBit;
        logic dcsEn;
        logic dcsLock;
        logic [2:0] divSel;
        logic [1:0] fmt;
        logic disA;
        logic disB;
        logic syncEn;
        logic syncOnce;
        logic syncArmed;
        logic longPath;
        logic [2:0] divCnt;
        logic [8:0] dcsCnt;
        logic [7:0] wakeCnt;
        logic [42:0][27:0] pipe;
        logic [9:0][1:0] orPipe;
        logic [13:0] slotB;
        logic orB;
        logic sampleClkInt;
        acc_out_t out;
    } acc_state_t;

endpackage

/* logic/acc_ctrl.sv */
// Function
// - divide input clock by one to eight
// - sync every strobe or first after write
// - accepted strobe restarts the clock divider
// - stabiliser enabled after reset by default
// - stabiliser regenerates falling edge for even duty
// - stabiliser idle below forty megahertz rate
// - relock wait bypasses stabiliser until locked
// - power-down from register bit or pin
// - power-down puts all drivers high-impedance
// - standby keeps reference, wakes faster
// - selectable offset binary, twos, Gray output
// - output-disable pin three-states data drivers
// - per-channel disable three-states data and overrange only when both are set
// - one channel disabled: other fills both slots
// - data latency 23 or 43 sample clocks
// - data clock output accompanies the data
// - overrange appears ten sample clocks later
// - overrange only beyond full scale, saturate
// - twos complement default, fixed extreme codes
// - offset binary extreme and zero codes
// - channels capture on internal clock rising
`timescale 1ns/10ps
`include "acc_consts.svh"

module acc_ctrl (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire acc_pkg::acc_apb_req_t apbReq,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic syncPin,
    input wire logic power_down_pin,
    input wire logic output_disable_pin,
    input wire acc_pkg::acc_samples_t samples,
    output logic sampleClkInt,
    output logic dcsLocked,
    output acc_pkg::acc_out_t outPins
);
    import acc_pkg::*;

    localparam int LAT_S = `ACC_LAT_SHORT;
    localparam int LAT_L = `ACC_LAT_LONG;
    localparam int OR_L = `ACC_OR_LAT;

    logic rstMeta_r;
    logic rstSync_b;
    acc_state_t s_r;
    acc_state_t s_nxt;

    logic pdActive;
    logic sbActive;
    logic running;
    logic sampleEn;
    logic halfHit;
    logic syncEdge;
    logic syncAccept;
    logic lowRate;
    logic apbSetup;
    logic apbWrite;
    logic [7:0] regIdx;
    logic [15:0] rawA;
    logic [15:0] rawB;
    logic [13:0] satA;
    logic [13:0] satB;
    logic ovA;
    logic ovB;
    logic [27:0] tap;
    logic [13:0] codeA;
    logic [13:0] codeB;
    logic [1:0] orTap;

    function automatic logic [13:0] encode(input logic [1:0] fmt, input logic [13:0] twos);
        logic [13:0] ob;
        ob = {~twos[13], twos[12:0]};
        unique case (fmt)
            `ACC_FMT_OFFS: encode = ob;
            `ACC_FMT_GRAY: encode = ob ^ (ob >> 1);
            default: encode = twos;
        endcase
    endfunction

    // Reset release passes two flops so its removal is clean
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_r <= 1'b0;
            rstSync_b <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_b <= rstMeta_r;
        end
    end

    assign pdActive = s_r.pdBit | s_r.pin2[1];
    assign sbActive = !pdActive && s_r.sbBit;
    assign running = !pdActive && !sbActive && (s_r.wakeCnt == 8'h00);
    assign sampleEn = running && (s_r.divCnt == 3'h0);
    assign halfHit = running && (s_r.divSel != 3'h0)
        && (s_r.divCnt == 3'((4'(s_r.divSel) + 4'h1) >> 1));
    assign syncEdge = s_r.pin2[0] && !s_r.syncPrev;
    assign syncAccept = syncEdge && s_r.syncEn && (!s_r.syncOnce || s_r.syncArmed);
    // Stabiliser loop cannot track an internal rate below its floor
    assign lowRate = (32'(s_r.divSel) + 32'd1) * `ACC_DCS_MIN_MHZ > `ACC_CLK_MHZ;
    assign apbSetup = apbReq.psel && !apbReq.penable;
    assign apbWrite = apbReq.psel && apbReq.penable && s_r.pready && apbReq.pwrite;
    assign regIdx = apbReq.paddr[9:2];

    assign rawA = samples.chanA;
    assign rawB = samples.chanB;
    assign ovA = ($signed(rawA) > `ACC_FS_POS) || ($signed(rawA) < `ACC_FS_NEG);
    assign ovB = ($signed(rawB) > `ACC_FS_POS) || ($signed(rawB) < `ACC_FS_NEG);
    assign satA = ($signed(rawA) > `ACC_FS_POS) ? `ACC_CODE_POS
        : (($signed(rawA) < `ACC_FS_NEG) ? `ACC_CODE_NEG : rawA[13:0]);
    assign satB = ($signed(rawB) > `ACC_FS_POS) ? `ACC_CODE_POS
        : (($signed(rawB) < `ACC_FS_NEG) ? `ACC_CODE_NEG : rawB[13:0]);
    assign tap = s_r.longPath ? s_r.pipe[LAT_L - 1] : s_r.pipe[LAT_S - 1];
    assign codeA = encode(s_r.fmt, tap[27:14]);
    assign codeB = encode(s_r.fmt, tap[13:0]);
    assign orTap = s_r.orPipe[OR_L - 1];

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pin1 = {output_disable_pin, power_down_pin, syncPin};
        s_nxt.pin2 = s_r.pin1;
        s_nxt.syncPrev = s_r.pin2[0];

        // Zero-wait slave: setup cycle prepares the answer, access lasts one cycle
        s_nxt.pready = apbSetup;
        if (apbSetup)
        begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0000_0000;
            unique case (regIdx)
                `ACC_IDX_PWR:
                begin
                    s_nxt.prdata[`ACC_PWR_PD_BIT] = s_r.pdBit;
                    s_nxt.prdata[`ACC_PWR_SB_BIT] = s_r.sbBit;
                end
                `ACC_IDX_DCS: s_nxt.prdata[`ACC_DCS_EN_BIT] = s_r.dcsEn;
                `ACC_IDX_DIV: s_nxt.prdata[2:0] = s_r.divSel;
                `ACC_IDX_OUT:
                begin
                    s_nxt.prdata[`ACC_OUT_FMT_LSB +: 2] = s_r.fmt;
                    s_nxt.prdata[`ACC_OUT_DIS_A_BIT] = s_r.disA;
                    s_nxt.prdata[`ACC_OUT_DIS_B_BIT] = s_r.disB;
                end
                `ACC_IDX_SYNC:
                begin
                    s_nxt.prdata[`ACC_SYNC_EN_BIT] = s_r.syncEn;
                    s_nxt.prdata[`ACC_SYNC_ONCE_BIT] = s_r.syncOnce;
                end
                `ACC_IDX_PATH: s_nxt.prdata[`ACC_PATH_LONG_BIT] = s_r.longPath;
                `ACC_IDX_STAT:
                begin
                    s_nxt.prdata[`ACC_STAT_LOCK_BIT] = s_r.out.clkOeB ? 1'b0 : dcsLocked;
                    s_nxt.prdata[`ACC_STAT_PD_BIT] = pdActive;
                    s_nxt.prdata[`ACC_STAT_SB_BIT] = sbActive;
                    s_nxt.prdata[`ACC_STAT_ARM_BIT] = s_r.syncArmed;
                    s_nxt.prdata[`ACC_STAT_WAKE_BIT] = (s_r.wakeCnt != 8'h00);
                end
                default: s_nxt.pslverr = 1'b1;
            endcase
        end

        // Sync arming: a sync register write in the same cycle as a strobe wins and leaves it armed
        if (syncAccept)
        begin
            s_nxt.syncArmed = 1'b0;
        end

        if (apbWrite)
        begin
            unique case (regIdx)
                `ACC_IDX_PWR:
                begin
                    s_nxt.pdBit = apbReq.pwdata[`ACC_PWR_PD_BIT];
                    s_nxt.sbBit = apbReq.pwdata[`ACC_PWR_SB_BIT];
                end
                `ACC_IDX_DCS: s_nxt.dcsEn = apbReq.pwdata[`ACC_DCS_EN_BIT];
                `ACC_IDX_DIV:
                begin
                    s_nxt.divSel = apbReq.pwdata[2:0];
                    if (apbReq.pwdata[2:0] != s_r.divSel)
                    begin
                        s_nxt.dcsCnt = 9'(`ACC_DCS_RELOCK_CYC);
                    end
                end
                `ACC_IDX_OUT:
                begin
                    s_nxt.fmt = apbReq.pwdata[`ACC_OUT_FMT_LSB +: 2];
                    s_nxt.disA = apbReq.pwdata[`ACC_OUT_DIS_A_BIT];
                    s_nxt.disB = apbReq.pwdata[`ACC_OUT_DIS_B_BIT];
                end
                `ACC_IDX_SYNC:
                begin
                    s_nxt.syncEn = apbReq.pwdata[`ACC_SYNC_EN_BIT];
                    s_nxt.syncOnce = apbReq.pwdata[`ACC_SYNC_ONCE_BIT];
                    s_nxt.syncArmed = 1'b1;
                end
                `ACC_IDX_PATH: s_nxt.longPath = apbReq.pwdata[`ACC_PATH_LONG_BIT];
                default:
                begin
                end
            endcase
        end

        // Divider; a strobe returns it to its initial count
        if (syncAccept)
        begin
            s_nxt.divCnt = 3'h0;
        end
        else if (s_r.divCnt >= s_r.divSel)
        begin
            s_nxt.divCnt = 3'h0;
        end
        else
        begin
            s_nxt.divCnt = s_r.divCnt + 3'h1;
        end

        if (s_r.dcsCnt != 9'h000 && !(apbWrite && regIdx == `ACC_IDX_DIV))
        begin
            s_nxt.dcsCnt = s_r.dcsCnt - 9'h001;
        end

        // Standby wakes faster since its reference stays up
        if (pdActive)
        begin
            s_nxt.wakeCnt = 8'(`ACC_WAKE_PD_CYC);
        end
        else if (sbActive)
        begin
            if (s_r.wakeCnt < 8'(`ACC_WAKE_SB_CYC))
            begin
                s_nxt.wakeCnt = 8'(`ACC_WAKE_SB_CYC);
            end
        end
        else if (s_r.wakeCnt != 8'h00)
        begin
            s_nxt.wakeCnt = s_r.wakeCnt - 8'h01;
        end

        // Internal clock: rises at each sample, falls at mid-period when stabilised
        if (sampleEn)
        begin
            s_nxt.sampleClkInt = 1'b1;
        end
        else if (dcsLocked && !lowRate ? halfHit : 1'b1)
        begin
            s_nxt.sampleClkInt = 1'b0;
        end

        if (sampleEn)
        begin
            s_nxt.pipe = {s_r.pipe[41:0], satA, satB};
            s_nxt.orPipe = {s_r.orPipe[8:0], ovA, ovB};
            s_nxt.out.dataClk = 1'b1;
            s_nxt.out.data = s_r.disA ? codeB : codeA;
            s_nxt.out.overRange = s_r.disA ? orTap[0] : orTap[1];
            s_nxt.slotB = s_r.disB ? codeA : codeB;
            s_nxt.orB = s_r.disB ? orTap[1] : orTap[0];
        end
        else if (halfHit)
        begin
            s_nxt.out.dataClk = 1'b0;
            s_nxt.out.data = s_r.slotB;
            s_nxt.out.overRange = s_r.orB;
        end

        s_nxt.out.dataOeB = pdActive || s_r.pin2[2] || (s_r.disA && s_r.disB);
        s_nxt.out.orOeB = pdActive || (s_r.disA && s_r.disB);
        s_nxt.out.clkOeB = pdActive;

        // Lock is worked out one cycle ahead so the pin comes straight from a flop
        s_nxt.dcsLock = s_nxt.dcsEn && (s_nxt.dcsCnt == 9'h000)
            && ((32'(s_nxt.divSel) + 32'd1) * `ACC_DCS_MIN_MHZ <= `ACC_CLK_MHZ);
    end

    always_ff @(posedge sys_clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            s_r <= '0;
            s_r.dcsEn <= `ACC_DCS_EN_RST;
            s_r.divSel <= `ACC_DIV_RST;
            s_r.fmt <= `ACC_FMT_RST;
            s_r.dcsCnt <= 9'(`ACC_DCS_RELOCK_CYC);
            s_r.out.dataOeB <= 1'b1;
            s_r.out.clkOeB <= 1'b1;
            s_r.out.orOeB <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign dcsLocked = s_r.dcsLock;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign prdata = s_r.prdata;
    assign sampleClkInt = s_r.sampleClkInt;
    assign outPins = s_r.out;

    sequence divWrite;
        apbWrite && regIdx == `ACC_IDX_DIV && apbReq.pwdata[2:0] != s_r.divSel;
    endsequence

    sequence pdRaised;
        $rose(pdActive);
    endsequence

    divider_period_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        sampleEn && !syncAccept && s_r.divSel == 3'h3 ##1 (running && !syncAccept
        && s_r.divSel == 3'h3) [*3] |-> !sampleEn)
        else $error("divider emitted an early sample");
    sync_restart_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        syncAccept && running |=> sampleEn)
        else $error("strobe did not restart divider");
    sync_once_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        syncEdge && s_r.syncOnce && !s_r.syncArmed && !apbWrite |=> !(s_r.divCnt == 3'h0
        && $past(s_r.divCnt) != $past(s_r.divSel)))
        else $error("disarmed one-shot strobe realigned divider");
    relock_bypass_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        divWrite |=> !dcsLocked [*8])
        else $error("stabiliser locked without relock wait");
    low_rate_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        s_r.divSel > 3'h4 |-> !dcsLocked)
        else $error("stabiliser locked below its rate floor");
    pd_hiz_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        pdRaised |=> outPins.dataOeB && outPins.clkOeB && outPins.orOeB)
        else $error("drivers active in power-down");
    pin_disable_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        $past(output_disable_pin, 3) && output_disable_pin |-> outPins.dataOeB)
        else $error("data driven with disable pin high");
    repeat_chan_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        halfHit && s_r.disB && !s_r.disA && $past(s_r.disB, 4) && !$past(s_r.disA, 4)
        && $stable(s_r.disB) |=>
        outPins.data == $past(outPins.data))
        else $error("remaining channel not repeated");
    or_latency_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        s_r.divSel == 3'h0 && $past(s_r.divSel, 10) == 3'h0 && running && $past(running, 11)
        |-> orTap[1] == $past(ovA, 10))
        else $error("overrange delay is not ten samples");
    path_latency_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        s_r.divSel == 3'h0 && !s_r.longPath && running && $past(running, 24)
        && $past(s_r.divSel, 23) == 3'h0 |-> tap[27:14] == $past(satA, 23))
        else $error("short path latency is not 23 samples");
    saturate_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        sampleEn && $signed(rawA) > `ACC_FS_POS |=> s_r.pipe[0][27:14] == `ACC_CODE_POS
        && s_r.orPipe[0][1])
        else $error("positive overrange did not saturate");

endmodule // acc_ctrl

/* tb/acc_capture_model.sv */
`timescale 1ns/10ps
module acc_capture_model (
    input wire logic sys_clk,
    input wire acc_pkg::acc_out_t outPins,
    output logic [13:0] capA,
    output logic [13:0] capB,
    output logic capOrA,
    output logic capOrB
);
    import acc_pkg::*;
    logic clkSeen = 1'b0;
    logic [13:0] lastBus = 14'h0000;
    logic lastOr = 1'b0;
    logic [13:0] busLine;
    logic orLine;
    logic clkLine;
    // Undriven data and overrange pairs toggle so a stale value is never captured; an undriven clock holds
    assign busLine = outPins.dataOeB ? ~lastBus : outPins.data;
    assign orLine = outPins.orOeB ? ~lastOr : outPins.overRange;
    assign clkLine = outPins.clkOeB ? clkSeen : outPins.dataClk;
    always @(posedge sys_clk)
    begin
        lastBus <= busLine;
        lastOr <= orLine;
        clkSeen <= clkLine;
        if (clkLine && !clkSeen)
        begin
            capA <= busLine;
            capOrA <= orLine;
        end
        if (!clkLine && clkSeen)
        begin
            capB <= busLine;
            capOrB <= orLine;
        end
    end
endmodule // acc_capture_model

/* tb/adc_clock_and_output_control_bench.sv */
`timescale 1ns/10ps
`include "acc_consts.svh"
module adc_clock_and_output_control_bench;
    import acc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    acc_apb_req_t apbReq = '0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic syncPin = 1'b0;
    logic power_down_pin = 1'b0;
    logic output_disable_pin = 1'b0;
    acc_samples_t samples = '0;
    logic sampleClkInt;
    logic dcsLocked;
    acc_out_t outPins;
    logic [13:0] capA;
    logic [13:0] capB;
    logic capOrA;
    logic capOrB;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;
    logic prevClk = 1'b0;
    int sinceRise = 0;
    int lastGap = 0;
    int n;
    int lat;
    int ratios[3] = '{3, 5, 8};
    int hiRun = 0;
    int lastHigh = 0;

    always #2.5 sys_clk = ~sys_clk;

    acc_ctrl i_acc_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .apbReq(apbReq), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .syncPin(syncPin), .power_down_pin(power_down_pin),
        .output_disable_pin(output_disable_pin), .samples(samples),
        .sampleClkInt(sampleClkInt), .dcsLocked(dcsLocked), .outPins(outPins));
    acc_capture_model i_acc_capture_model (.sys_clk(sys_clk), .outPins(outPins),
        .capA(capA), .capB(capB), .capOrA(capOrA), .capOrB(capOrB));

    // Gap in cycles between data clock rises gives the divide ratio
    always @(posedge sys_clk)
    begin
        prevClk <= outPins.dataClk;
        sinceRise <= (outPins.dataClk && !prevClk) ? 1 : sinceRise + 1;
        if (outPins.dataClk && !prevClk)
            lastGap <= sinceRise;
    end

    // High run of the internal sample clock gives its duty
    always @(posedge sys_clk)
    begin
        hiRun <= sampleClkInt ? hiRun + 1 : 0;
        if (!sampleClkInt && hiRun != 0)
            lastHigh <= hiRun;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // One idle cycle before each setup keeps every signal to one assignment per step
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge sys_clk);
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= wr;
        apbReq.paddr <= {idx, 2'b00};
        apbReq.pwdata <= wd;
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    function automatic logic [13:0] code14(input logic [1:0] fmt, input logic [13:0] t);
        logic [13:0] off;
        off = t ^ 14'h2000;
        if (fmt == `ACC_FMT_TWOS)
            return t;
        if (fmt == `ACC_FMT_OFFS)
            return off;
        return off ^ (off >> 1);
    endfunction

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        summarize();
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        cyc(4);
        apb(1'b0, `ACC_IDX_DCS, 32'h0);
        check("dcs enable", 32'(rd[0]), 32'(`ACC_DCS_EN_RST));
        samples.chanA <= 16'h3000;
        apb(1'b0, 8'h01, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        cyc(320);
        check("dcs locked", 32'(dcsLocked), 32'h1);
        apb(1'b1, `ACC_IDX_DIV, 32'h3);
        for (int s = 0; s < 2; s++)
            for (int f = 0; f < 3; f++)
            begin
                samples.chanA <= (s == 1) ? 16'h1fff : 16'h3000;
                samples.chanB <= (s == 1) ? 16'he000 : 16'hd000;
                apb(1'b1, `ACC_IDX_OUT, 32'(f));
                cyc(250);
                check("code a", 32'(capA), 32'(code14(f[1:0], 14'h1fff)));
                check("code b", 32'(capB), 32'(code14(f[1:0], 14'h2000)));
                check("overrange a", 32'(capOrA), 32'(s == 0));
                check("overrange b", 32'(capOrB), 32'(s == 0));
            end
        samples.chanA <= 16'h0100;
        samples.chanB <= 16'h0200;
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `ACC_IDX_OUT, (i == 1) ? 32'h10 : 32'h20);
            cyc(250);
            check("repeat a", 32'(capA), (i == 1) ? 32'h200 : 32'h100);
            check("repeat b", 32'(capB), (i == 1) ? 32'h200 : 32'h100);
        end
        apb(1'b1, `ACC_IDX_OUT, 32'h0);
        apb(1'b1, `ACC_IDX_DIV, 32'h1);
        for (int p = 0; p < 2; p++)
        begin
            lat = (p == 1) ? `ACC_LAT_LONG : `ACC_LAT_SHORT;
            samples.chanA <= 16'h0000;
            apb(1'b1, `ACC_IDX_PATH, 32'(p));
            cyc(300);
            samples.chanA <= 16'h0123;
            n = 0;
            while (capA !== 14'h0123 && n < 200)
            begin
                @(posedge sys_clk);
                n++;
            end
            check("latency", 32'(n >= (lat - 1) * 2 && n <= (lat + 2) * 2 + 4), 32'h1);
        end
        output_disable_pin <= 1'b1;
        cyc(6);
        check("oeb pin high", 32'(outPins.dataOeB), 32'h1);
        output_disable_pin <= 1'b0;
        cyc(6);
        check("oeb pin low", 32'(outPins.dataOeB), 32'h0);
        power_down_pin <= 1'b1;
        cyc(6);
        check("pd pin drivers", 32'({outPins.dataOeB, outPins.clkOeB, outPins.orOeB}), 32'h7);
        apb(1'b0, `ACC_IDX_STAT, 32'h0);
        check("pd status", 32'(rd[`ACC_STAT_PD_BIT]), 32'h1);
        power_down_pin <= 1'b0;
        cyc(260);
        check("pd pin release", 32'(outPins.dataOeB), 32'h0);
        apb(1'b1, `ACC_IDX_PWR, 32'h1);
        cyc(4);
        check("pd bit drivers", 32'({outPins.dataOeB, outPins.clkOeB, outPins.orOeB}), 32'h7);
        apb(1'b1, `ACC_IDX_PWR, 32'h2);
        apb(1'b0, `ACC_IDX_STAT, 32'h0);
        check("standby status", 32'(rd[`ACC_STAT_SB_BIT]), 32'h1);
        check("standby drivers", 32'(outPins.dataOeB), 32'h0);
        apb(1'b1, `ACC_IDX_PWR, 32'h0);
        cyc(260);
        foreach (ratios[i])
        begin
            apb(1'b1, `ACC_IDX_DIV, 32'(ratios[i] - 1));
            cyc(3);
            check("relock bypass", 32'(dcsLocked), 32'h0);
            cyc(310);
            check("dcs by rate", 32'(dcsLocked), 32'(ratios[i] < 6));
            check("divide ratio", 32'(lastGap), 32'(ratios[i]));
            check("duty high", 32'(lastHigh), 32'((ratios[i] < 6) ? ratios[i] / 2 : 1));
        end
        apb(1'b1, `ACC_IDX_SYNC, 32'h2);
        for (int k = 1; k < 3; k++)
        begin
            do
            begin
                @(posedge sys_clk);
            end
            while (!(outPins.dataClk === 1'b1 && prevClk === 1'b0));
            // Strobe lands in the low half, ahead of the natural rise
            cyc(k);
            syncPin <= 1'b1;
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
            end
            while (!(outPins.dataClk === 1'b1 && prevClk === 1'b0) && n < 20);
            check("sync realign", 32'(n), 32'h5);
            syncPin <= 1'b0;
            cyc(12);
        end
        apb(1'b1, `ACC_IDX_SYNC, 32'h6);
        apb(1'b0, `ACC_IDX_STAT, 32'h0);
        check("sync armed", 32'(rd[`ACC_STAT_ARM_BIT]), 32'h1);
        syncPin <= 1'b1;
        cyc(8);
        syncPin <= 1'b0;
        apb(1'b0, `ACC_IDX_STAT, 32'h0);
        check("sync spent", 32'(rd[`ACC_STAT_ARM_BIT]), 32'h0);
        syncPin <= 1'b1;
        cyc(8);
        syncPin <= 1'b0;
        apb(1'b0, `ACC_IDX_STAT, 32'h0);
        check("sync stays spent", 32'(rd[`ACC_STAT_ARM_BIT]), 32'h0);
        summarize();
    end
endmodule // adc_clock_and_output_control_bench
